// ---- src/led_ctl_pkg.sv ----
// constants and types shared by the led expander control core
package led_ctl_pkg;
  localparam int PORT_COUNT  = 28;
  localparam int PORT_BASE   = 4;
  localparam int MON_COUNT   = 7;
  localparam int MON_BASE    = 24;
  localparam int IRQ_PORT    = 31;
  localparam int SEG_PAIRS   = 14;
  localparam int LEVEL_W     = 4;

  localparam logic [7:0] ADDR_GLOBAL_CURRENT = 8'h02;
  localparam logic [7:0] ADDR_CONFIG         = 8'h04;
  localparam logic [7:0] ADDR_MASK           = 8'h06;
  localparam logic [7:0] ADDR_DISPLAY_TEST   = 8'h07;
  localparam logic [7:0] ADDR_SEG_CUR_FIRST  = 8'h12;
  localparam logic [7:0] ADDR_SEG_CUR_LAST   = 8'h1f;

  localparam int CFG_RUN_BIT   = 0;
  localparam int CFG_INDIV_BIT = 6;
  localparam int CFG_MON_BIT   = 7;
  localparam int MASK_FLAG_BIT = 7;
  localparam int TEST_BIT      = 0;

  localparam logic [7:0]         CONFIG_RESET  = 8'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET   = 4'h0;
  localparam logic [6:0]         MASK_RESET    = 7'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_HALF    = 4'h7;
  localparam logic [LEVEL_W-1:0] LEVEL_OFF     = 4'h0;

  // port modes, two config bits per port
  localparam logic [1:0] MODE_LED     = 2'h0;
  localparam logic [1:0] MODE_OUTPUT  = 2'h1;
  localparam logic [1:0] MODE_INPUT   = 2'h2;
  localparam logic [1:0] MODE_PULLUP  = 2'h3;

  typedef enum logic [2:0] {
    DET_IDLE  = 3'b001,
    DET_ARMED = 3'b010,
    DET_FIRED = 3'b100
  } det_state_t;
endpackage

// ---- src/det_if.sv ----
// detector carrier between the control core and the transition detector
`timescale 1ns/1ps
interface det_if;
  import led_ctl_pkg::*;
  logic                 arm;
  logic                 disarm;
  logic                 clearFlag;
  logic [MON_COUNT-1:0] mask;
  logic [MON_COUNT-1:0] levels;
  logic                 flag;
  logic                 armed;
  modport core (output arm, output disarm, output clearFlag, output mask,
                output levels, input flag, input armed);
  modport det  (input arm, input disarm, input clearFlag, input mask,
                input levels, output flag, output armed);
endinterface

// ---- src/transition_detect.sv ----
// one-shot transition detector with snapshot and sticky change flag
`timescale 1ns/1ps
module transition_detect
  import led_ctl_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  det_if.det        dio
);
  typedef struct packed {
    det_state_t           state;
    logic [MON_COUNT-1:0] snap;
    logic                 flag;
  } det_reg_t;

  det_reg_t r_q;
  det_reg_t r_d;
  logic     diff;

  always_comb
  begin
    r_d  = r_q;
    diff = |((dio.levels ^ r_q.snap) & dio.mask);
    case (r_q.state)
      DET_IDLE:
      begin
        if (dio.arm)
        begin
          r_d.state = DET_ARMED;
          r_d.snap  = dio.levels;
          r_d.flag  = 1'b0;
        end
      end
      DET_ARMED:
      begin
        if (dio.arm)
        begin
          r_d.snap = dio.levels;
          r_d.flag = 1'b0;
        end
        else if (dio.disarm)
          r_d.state = DET_IDLE;
        else if (diff)
        begin
          r_d.state = DET_FIRED;
          r_d.flag  = 1'b1;
        end
      end
      DET_FIRED:
      begin
        if (dio.arm)
        begin
          r_d.state = DET_ARMED;
          r_d.snap  = dio.levels;
          r_d.flag  = 1'b0;
        end
        else if (dio.clearFlag)
        begin
          r_d.state = DET_IDLE;
          r_d.flag  = 1'b0;
        end
      end
      default:
        r_d.state = DET_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      r_q.state <= DET_IDLE;
      r_q.snap  <= MASK_RESET;
      r_q.flag  <= 1'b0;
    end
    else
      r_q <= r_d;
  end

  assign dio.flag  = r_q.flag;
  assign dio.armed = (r_q.state == DET_ARMED);
endmodule

// ---- src/led_expander_config_transition_detect.sv ----
// control core: configuration, current select, transition detect, display test
// Contract
// - configuration bit 0: zero is shutdown, one is normal operation
// - individual bit clear: every led port uses the global current setting
// - individual bit set: each segment uses its own nibble, global ignored
// - configuration bit 7 enables transition detection
// - global current low nibble picks 1/16..16/16; upper nibble ignored
// - seven mask bits include or exclude each monitored port
// - monitored ports compare regardless of input or output mode
// - configuration write with monitor bit loads 7-bit snapshot of monitored ports
// - snapshot reloads on every such write, even if already enabled
// - armed until written with monitor bit clear or a transition seen
// - arming clears change flag and drives interrupt output low
// - any monitored difference while armed sets flag and raises interrupt
// - flag and interrupt stay set despite further changes or return
// - only mask register read or write, or a configuration write with monitor bit set, clears flag and interrupt
// - after clearing a fired flag detection disarms, monitor bit still reads set
// - display test turns on all led ports, registers unchanged
// - display test leaves push-pull outputs at their current state
// - display test drives led ports at half maximum current
// - interrupt port as output becomes active-high mirror of change flag
`timescale 1ns/1ps
module led_expander_config_transition_detect
  import led_ctl_pkg::*;
#(
  parameter int NUM_PORTS = PORT_COUNT
)
(
  input  wire logic                             mclk,
  input  wire logic                             rst,
  input  wire logic                             regWrite,
  input  wire logic                             regRead,
  input  wire logic [7:0]                       regAddr,
  input  wire logic [7:0]                       regWdata,
  output logic      [7:0]                       regRdata,
  input  wire logic [2*NUM_PORTS-1:0]           portMode,
  input  wire logic [NUM_PORTS-1:0]             portData,
  input  wire logic [NUM_PORTS-1:0]             portLevel,
  output logic      [NUM_PORTS-1:0]             ledOn,
  output logic      [LEVEL_W*NUM_PORTS-1:0]     ledCurrent,
  output logic      [NUM_PORTS-1:0]             gpioOut,
  output logic                                  runEnable,
  output logic                                  irqOut,
  output logic                                  irqOutEn
);
  import led_ctl_pkg::*;

  typedef struct packed {
    logic [7:0]                   config_;
    logic [LEVEL_W-1:0]           globalLevel;
    logic [MON_COUNT-1:0]         mask;
    logic                         test;
    logic [2*SEG_PAIRS*LEVEL_W-1:0] segLevel;
    logic [7:0]                   rdata;
    logic [NUM_PORTS-1:0]         ledOn;
    logic [LEVEL_W*NUM_PORTS-1:0] ledCurrent;
    logic [NUM_PORTS-1:0]         gpioOut;
    logic                         run;
    logic                         irq;
    logic                         irqEn;
  } core_reg_t;

  core_reg_t core_q;
  core_reg_t core_d;
  det_if     det();

  // monitored port index for mask bit n
  function automatic int monPort(input int n);
    monPort = MON_BASE - PORT_BASE + n;
  endfunction

  function automatic logic [1:0] modeOf(input logic [2*NUM_PORTS-1:0] m, input int p);
    modeOf = m[2*p +: 2];
  endfunction

  logic cfgWrite;
  logic maskAccess;
  logic [NUM_PORTS-1:0] isLed;
  logic [LEVEL_W-1:0]   portLvl [NUM_PORTS];

  assign cfgWrite   = regWrite && (regAddr == ADDR_CONFIG);
  assign maskAccess = (regWrite || regRead) && (regAddr == ADDR_MASK);

  assign det.arm       = cfgWrite && regWdata[CFG_MON_BIT];
  assign det.disarm    = cfgWrite && !regWdata[CFG_MON_BIT];
  assign det.clearFlag = maskAccess;
  assign det.mask      = core_q.mask;

  genvar g;
  generate
    for (g = 0; g < MON_COUNT; g++)
    begin : g_mon
      assign det.levels[g] = portLevel[monPort(g)];
    end
    for (g = 0; g < NUM_PORTS; g++)
    begin : g_port
      assign isLed[g] = (modeOf(portMode, g) == MODE_LED);
      // segment nibble: even ports low nibble, odd ports high nibble
      assign portLvl[g] = core_q.config_[CFG_INDIV_BIT]
                        ? core_q.segLevel[LEVEL_W*g +: LEVEL_W]
                        : core_q.globalLevel;
    end
  endgenerate

  transition_detect u_det (
    .mclk (mclk),
    .rst  (rst),
    .dio  (det)
  );

  always_comb
  begin
    core_d = core_q;
    if (regWrite)
    begin
      case (regAddr)
        ADDR_GLOBAL_CURRENT: core_d.globalLevel = regWdata[LEVEL_W-1:0];
        ADDR_CONFIG:         core_d.config_     = regWdata;
        ADDR_MASK:           core_d.mask        = regWdata[MON_COUNT-1:0];
        ADDR_DISPLAY_TEST:   core_d.test        = regWdata[TEST_BIT];
        default:
        begin
          if (regAddr >= ADDR_SEG_CUR_FIRST && regAddr <= ADDR_SEG_CUR_LAST)
            core_d.segLevel[8*(regAddr - ADDR_SEG_CUR_FIRST) +: 8] = regWdata;
        end
      endcase
    end
    case (regAddr)
      ADDR_GLOBAL_CURRENT: core_d.rdata = {4'h0, core_q.globalLevel};
      ADDR_CONFIG:         core_d.rdata = {core_q.config_[CFG_MON_BIT],
                                           core_q.config_[CFG_INDIV_BIT], 5'h00,
                                           core_q.config_[CFG_RUN_BIT]};
      ADDR_MASK:           core_d.rdata = {det.flag, core_q.mask};
      ADDR_DISPLAY_TEST:   core_d.rdata = {7'h00, core_q.test};
      default:
      begin
        if (regAddr >= ADDR_SEG_CUR_FIRST && regAddr <= ADDR_SEG_CUR_LAST)
          core_d.rdata = core_q.segLevel[8*(regAddr - ADDR_SEG_CUR_FIRST) +: 8];
        else
          core_d.rdata = 8'h00;
      end
    endcase
    core_d.run = core_q.config_[CFG_RUN_BIT];
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (core_q.test && isLed[p])
      begin
        core_d.ledOn[p]                    = 1'b1;
        core_d.ledCurrent[LEVEL_W*p +: LEVEL_W] = LEVEL_HALF;
      end
      else
      begin
        core_d.ledOn[p] = isLed[p] && portData[p] && core_q.config_[CFG_RUN_BIT];
        core_d.ledCurrent[LEVEL_W*p +: LEVEL_W] = isLed[p] ? portLvl[p] : LEVEL_OFF;
      end
      core_d.gpioOut[p] = portData[p];
    end
    core_d.irqEn = (modeOf(portMode, IRQ_PORT - PORT_BASE) == MODE_OUTPUT);
    core_d.irq   = det.flag;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      core_q.config_     <= CONFIG_RESET;
      core_q.globalLevel <= LEVEL_RESET;
      core_q.mask        <= MASK_RESET;
      core_q.test        <= 1'b0;
      core_q.segLevel    <= '0;
      core_q.rdata       <= 8'h00;
      core_q.ledOn       <= '0;
      core_q.ledCurrent  <= '0;
      core_q.gpioOut     <= '0;
      core_q.run         <= 1'b0;
      core_q.irq         <= 1'b0;
      core_q.irqEn       <= 1'b0;
    end
    else
      core_q <= core_d;
  end

  assign regRdata   = core_q.rdata;
  assign ledOn      = core_q.ledOn;
  assign ledCurrent = core_q.ledCurrent;
  assign gpioOut    = core_q.gpioOut;
  assign runEnable  = core_q.run;
  assign irqOut     = core_q.irq;
  assign irqOutEn   = core_q.irqEn;
endmodule

// ---- bench/bus_master_model.sv ----
// register access master model for the control core
`timescale 1ns/1ps
module bus_master_model
(
  input  wire logic       mclk,
  output logic            regWrite,
  output logic            regRead,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWdata,
  input  wire logic [7:0] regRdata
);
  initial
  begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 8'h00;
    regWdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regAddr  = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge mclk);
    regWrite = 1'b0;
    regWdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge mclk);
    regRead = 1'b0;
    d       = regRdata;
  endtask
endmodule

// ---- bench/led_ctl_asserts.sv ----
// port checks for the led expander control core
`timescale 1ns/1ps
module led_ctl_asserts
  import led_ctl_pkg::*;
#(
  parameter int NUM_PORTS = PORT_COUNT
)
(
  input wire logic                         mclk,
  input wire logic                         rst,
  input wire logic                         regWrite,
  input wire logic                         regRead,
  input wire logic [7:0]                   regAddr,
  input wire logic [7:0]                   regWdata,
  input wire logic [7:0]                   regRdata,
  input wire logic [2*NUM_PORTS-1:0]       portMode,
  input wire logic [NUM_PORTS-1:0]         portData,
  input wire logic [NUM_PORTS-1:0]         portLevel,
  input wire logic [NUM_PORTS-1:0]         ledOn,
  input wire logic [LEVEL_W*NUM_PORTS-1:0] ledCurrent,
  input wire logic [NUM_PORTS-1:0]         gpioOut,
  input wire logic                         runEnable,
  input wire logic                         irqOut,
  input wire logic                         irqOutEn
);
  logic cfgWr;
  logic armWr;
  logic maskAcc;
  logic testQ;
  assign cfgWr   = regWrite && regAddr == ADDR_CONFIG;
  assign armWr   = cfgWr && regWdata[CFG_MON_BIT];
  assign maskAcc = (regWrite || regRead) && regAddr == ADDR_MASK;
  always_ff @(posedge mclk)
  begin
    if (rst)
      testQ <= 1'b0;
    else if (regWrite && regAddr == ADDR_DISPLAY_TEST)
      testQ <= regWdata[TEST_BIT];
  end
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_disarm;
    cfgWr && !regWdata[CFG_MON_BIT] ##1 !armWr ##1 !irqOut && !armWr ##1 !armWr;
  endsequence
  sequence s_cfgHold;
    cfgWr ##1 regAddr == ADDR_CONFIG && !regWrite;
  endsequence
  property p_run;
    cfgWr |-> ##2 runEnable == $past(regWdata[CFG_RUN_BIT], 2);
  endproperty
  property p_irqEn;
    1'b1 |=> irqOutEn == ($past(portMode[2*(IRQ_PORT-PORT_BASE) +: 2]) == MODE_OUTPUT);
  endproperty
  property p_cfgRead;
    s_cfgHold |=> regRdata == ($past(regWdata, 2) & 8'hc1);
  endproperty
  property p_arm;
    armWr |-> ##2 !irqOut;
  endproperty
  property p_sticky;
    irqOut && !maskAcc && !$past(maskAcc) && !armWr && !$past(armWr) |=> irqOut;
  endproperty
  property p_clear;
    maskAcc && irqOut && !$past(armWr) |-> ##2 !irqOut;
  endproperty
  property p_disarm;
    s_disarm |=> !irqOut [*3];
  endproperty
  property p_testLit;
    testQ && portMode[1:0] == MODE_LED |=> ledOn[0] && ledCurrent[3:0] == LEVEL_HALF;
  endproperty
  property p_testGpio;
    testQ |=> gpioOut == $past(portData);
  endproperty
  a_run: assert property (p_run)
    else $error("run enable differs from config bit");
  a_irqEn: assert property (p_irqEn)
    else $error("interrupt enable wrong");
  a_arm: assert property (p_arm)
    else $error("interrupt not low after arming");
  a_sticky: assert property (p_sticky)
    else $error("interrupt dropped without mask access");
  a_clear: assert property (p_clear)
    else $error("interrupt not cleared by mask access");
  a_disarm: assert property (p_disarm)
    else $error("interrupt raised while disarmed");
  a_testLit: assert property (p_testLit)
    else $error("display test led wrong");
  a_testGpio: assert property (p_testGpio)
    else $error("display test changed gpio");
  a_cfgRead: assert property (p_cfgRead)
    else $error("config readback wrong");
endmodule

bind led_expander_config_transition_detect led_ctl_asserts #(.NUM_PORTS(NUM_PORTS))
  u_led_ctl_asserts (.mclk(mclk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
  .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .portMode(portMode),
  .portData(portData), .portLevel(portLevel), .ledOn(ledOn), .ledCurrent(ledCurrent),
  .gpioOut(gpioOut), .runEnable(runEnable), .irqOut(irqOut), .irqOutEn(irqOutEn));

// ---- bench/led_expander_config_transition_detect_tb_top.sv ----
// self-checking bench for the led expander control core
`timescale 1ns/1ps
module led_expander_config_transition_detect_tb_top;
  import led_ctl_pkg::*;
  logic         mclk = 1'b0;
  logic         rst = 1'b1;
  logic         regWrite;
  logic         regRead;
  logic [7:0]   regAddr;
  logic [7:0]   regWdata;
  logic [7:0]   regRdata;
  logic [55:0]  portMode;
  logic [27:0]  portData;
  logic [27:0]  portLevel;
  logic [27:0]  ledOn;
  logic [111:0] ledCurrent;
  logic [27:0]  gpioOut;
  logic         runEnable;
  logic         irqOut;
  logic         irqOutEn;
  int           failures = 0;
  int           n_compared = 0;
  int           cycles = 0;

  bus_master_model u_bus_master_model (.mclk(mclk), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
  led_expander_config_transition_detect u_led_expander_config_transition_detect (
    .mclk(mclk), .rst(rst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .portMode(portMode), .portData(portData),
    .portLevel(portLevel), .ledOn(ledOn), .ledCurrent(ledCurrent), .gpioOut(gpioOut),
    .runEnable(runEnable), .irqOut(irqOut), .irqOutEn(irqOutEn));

  always #5 mclk = ~mclk;

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      failures = failures + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_bus_master_model.rd(a, d);
    chk(d, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_bus_master_model.wr(a, d);
  endtask

  task automatic irq(input logic e);
    repeat (3) @(negedge mclk);
    chk({7'h00, irqOut}, {7'h00, e});
  endtask

  task automatic pulse(input int i);
    @(negedge mclk);
    portLevel[i] = ~portLevel[i];
    @(negedge mclk);
    portLevel[i] = ~portLevel[i];
  endtask

  initial
  begin
    portMode = {28{MODE_INPUT}};
    portMode[3:0] = {MODE_LED, MODE_LED};
    portMode[5:4] = MODE_OUTPUT;
    portMode[55:54] = MODE_OUTPUT;
    portData = 28'h0000005;
    portLevel = 28'h0000000;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    rdchk(ADDR_CONFIG, 8'h00);
    rdchk(ADDR_GLOBAL_CURRENT, 8'h00);
    rdchk(8'h40, 8'h00);
    chk({7'h00, irqOutEn}, 8'h01);
    $display("test reset done");
    wr(ADDR_CONFIG, 8'h01);
    wr(ADDR_GLOBAL_CURRENT, 8'hf5);
    @(negedge mclk);
    chk({7'h00, runEnable}, 8'h01);
    chk(ledCurrent[7:0], 8'h55);
    wr(ADDR_SEG_CUR_FIRST, 8'h3a);
    wr(ADDR_CONFIG, 8'h41);
    @(negedge mclk);
    chk(ledCurrent[7:0], 8'h3a);
    chk({6'h00, ledOn[1:0]}, 8'h01);
    $display("test currents done");
    wr(ADDR_DISPLAY_TEST, 8'h01);
    @(negedge mclk);
    chk({6'h00, ledOn[1:0]}, 8'h03);
    chk(ledCurrent[7:0], {LEVEL_HALF, LEVEL_HALF});
    chk({7'h00, gpioOut[2]}, 8'h01);
    rdchk(ADDR_CONFIG, 8'h41);
    wr(ADDR_DISPLAY_TEST, 8'h00);
    $display("test display done");
    wr(ADDR_MASK, 8'h7f);
    wr(ADDR_CONFIG, 8'h81);
    pulse(20);
    irq(1'b1);
    pulse(20);
    irq(1'b1);
    rdchk(ADDR_MASK, 8'hff);
    rdchk(ADDR_MASK, 8'h7f);
    irq(1'b0);
    rdchk(ADDR_CONFIG, 8'h81);
    pulse(21);
    irq(1'b0);
    $display("test detect done");
    wr(ADDR_MASK, 8'h7e);
    wr(ADDR_CONFIG, 8'h81);
    portLevel[20] = 1'b1;
    irq(1'b0);
    wr(ADDR_CONFIG, 8'h81);
    wr(ADDR_MASK, 8'h7f);
    irq(1'b0);
    wr(ADDR_CONFIG, 8'h01);
    pulse(21);
    irq(1'b0);
    portMode[43:42] = MODE_OUTPUT;
    wr(ADDR_CONFIG, 8'h81);
    pulse(21);
    irq(1'b1);
    rdchk(ADDR_MASK, 8'hff);
    $display("test rearm done");
    tally_and_finish();
  end
endmodule
